// ### verilog/nscr_defines.svh
// Register map, field positions, reset values and timing counts of the
// network status and command register block.
// Assumes the host clock runs at the rate given by NSCR_CLK_MHZ.
`ifndef NSCR_DEFINES_SVH
`define NSCR_DEFINES_SVH

// Host-visible register addresses.
`define NSCR_ADDR_RXBASE 32'h2000800c
`define NSCR_ADDR_TXBASE 32'h20008010
`define NSCR_ADDR_STATUS 32'h20008014
`define NSCR_ADDR_CMD 32'h20008018

// Reset values, read-as-one masks and the mask of writable low command bits.
`define NSCR_STATUS_RESET 32'h0039ff00
`define NSCR_STATUS_ONES 32'h0038ff00
`define NSCR_CMD_RESET 32'h03e0f000
`define NSCR_CMD_ONES 32'h01e0f000
`define NSCR_CMD_LOW_MASK 8'hce
`define NSCR_BL_DEFAULT 4'h1

// Status word field positions.
`define NSCR_SB_INIT 31
`define NSCR_SB_SF 30
`define NSCR_SB_SS_HI 29
`define NSCR_SB_SS_LO 26
`define NSCR_SB_TS_HI 25
`define NSCR_SB_TS_LO 24
`define NSCR_SB_RS_HI 23
`define NSCR_SB_RS_LO 22
`define NSCR_SB_OM_HI 18
`define NSCR_SB_OM_LO 17
`define NSCR_SB_DN 16
`define NSCR_SB_BO 7
`define NSCR_SB_TW 6
`define NSCR_SB_RW 5
`define NSCR_SB_ME 4
`define NSCR_SB_RU 3
`define NSCR_SB_RI 2
`define NSCR_SB_TI 1
`define NSCR_SB_IS 0

// Command word field positions.
`define NSCR_CB_RE 31
`define NSCR_CB_IE 30
`define NSCR_CB_BL_HI 28
`define NSCR_CB_BL_LO 25
`define NSCR_CB_BE 20
`define NSCR_CB_SE 19
`define NSCR_CB_ST 11
`define NSCR_CB_SR 10
`define NSCR_CB_OM_HI 9
`define NSCR_CB_OM_LO 8

// Timing: self-test time in microseconds, boot pulse in host cycles; event FIFO depth in words.
`define NSCR_CLK_MHZ 40
`define NSCR_SELFTEST_US 25000
`define NSCR_SELFTEST_CYCLES (`NSCR_SELFTEST_US * `NSCR_CLK_MHZ)
`define NSCR_BOOT_PULSE_CYCLES 3'h6
`define NSCR_FIFO_DEPTH 32

`endif

// ### verilog/nscr_pkg.sv
// Types shared by the network status and command register block.
// Assumes nscr_defines.svh supplies every number.
`default_nettype none
package nscr_pkg;

    // Process state codes of the transmit and receive processes.
    typedef enum logic [1:0] {
        NSCR_PS_STOPPED = 2'b00,
        NSCR_PS_RUNNING = 2'b01,
        NSCR_PS_SUSPENDED = 2'b10
    } nscr_pstate_t;

    // Two-phase status update sequencer.
    typedef enum logic [1:0] {
        NSCR_PH_IDLE = 2'b00,
        NSCR_PH_HIGH = 2'b01,
        NSCR_PH_LOW = 2'b10
    } nscr_phase_t;

    // Host register request, one access per cycle.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wperr;
    } nscr_req_t;

    // One event word reported by the frame engine.
    typedef struct packed {
        logic tx_wdog;
        logic rx_wdog;
        logic tx_empty;
        logic tx_err;
        logic tx_ic;
        logic rx_unavail;
        logic rx_frame;
        logic rx_resume;
        logic tx_resume;
        logic boot_msg;
        logic access_start;
        logic access_done;
    } nscr_evt_t;

    // Whole state of the register block.
    typedef struct packed {
        logic init_done;
        logic selftest_failed;
        logic [3:0] selftest_code;
        nscr_pstate_t tx_process_state;
        nscr_pstate_t rx_process_state;
        logic [1:0] operating_mode;
        logic access_done;
        logic boot_msg_seen;
        logic tx_watchdog_flag;
        logic rx_watchdog_flag;
        logic memory_error_flag;
        logic rx_buffer_unavailable;
        logic rx_interrupt_flag;
        logic tx_interrupt_flag;
        logic interrupt_enable;
        logic [3:0] burst_limit;
        logic boot_msg_enable;
        logic single_cycle_enable;
        logic tx_start_stop;
        logic rx_start_stop;
        logic [7:0] low_modes;
        logic tx_base_ok;
        logic rx_base_ok;
        logic tx_stop_pend;
        logic rx_stop_pend;
        logic [19:0] init_cnt;
        nscr_phase_t phase;
        nscr_evt_t ev;
        logic [2:0] boot_cnt;
        logic [31:0] rdata;
        logic rvalid;
        logic irq;
        logic boot_n;
        logic abort;
        logic [3:0] burst_eff;
    } nscr_state_t;

endpackage
`default_nettype wire

// ### verilog/nscr_regs.sv
// Status and command registers of the network controller, with the event
// FIFO that carries frame engine events into the status word.
// Assumes one host clock, host requests synchronous to it, and a frame
// engine that reports events as words and busy levels per process.
//
// Functional notes
// - Report tx and rx process states, two bits.
// - Operating mode from command, mirrored in status.
// - Rx watchdog sets flag and rx interrupt, runs.
// - Bus or parity error sets flag, stops both.
// - Rx unavailable suspends reception, flags each time while suspended.
// - Frame received sets rx interrupt, keeps running.
// - Tx list end or error suspends, flags interrupt.
// - Summary bit is OR of bits six..one.
// - Status resets defined; bits seven..one write-one-clear.
// - Host-caused changes raise no interrupt.
// - Own state changes come with event flags, except resumes.
// - High half first, low half within four cycles.
// - Reset command aborts and reruns self-test.
// - Interrupt enable lets event flags interrupt.
// - Burst limit one..eight, single-cycle forcing.
// - Boot message sets flag, pulses boot output.
// - Transmit start and stop commands.
// - Receive start and stop commands.
// - Init done gates commands; processes then stopped.
`timescale 1ns/10ps
`default_nettype none
`include "nscr_defines.svh"

// Plain FIFO; storage in flip-flops, both ready and valid from state.
module nscr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = `NSCR_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    // Pointer arithmetic wraps naturally only for a power of two.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
        logic vld;
    } nscr_fifo_state_t;

    nscr_fifo_state_t s_q; // Registered state.
    nscr_fifo_state_t s_d; // Next state.
    logic push; // Word accepted this cycle.
    logic pop; // Word handed out this cycle.

    // Next state; ready and valid are precomputed so they leave flops.
    always_comb begin
        s_d = s_q;
        push = in_valid_in && s_q.rdy;
        pop = out_ready_in && s_q.vld;
        if (push) begin
            s_d.mem[s_q.wp] = in_data_in;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
        s_d.vld = (s_d.cnt != '0);
    end

    // State register.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_out = s_q.rdy;
    assign out_valid_out = s_q.vld;
    assign out_data_out = s_q.mem[s_q.rp];
endmodule

module nscr_regs import nscr_pkg::*; #(
    parameter int SELFTEST_CYCLES = `NSCR_SELFTEST_CYCLES,
    parameter int EVT_DEPTH = `NSCR_FIFO_DEPTH
) (
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire nscr_req_t HOST_REQ_IN,
    output logic [31:0] HOST_RDATA_OUT,
    output logic HOST_RVALID_OUT,
    input wire logic EVT_VALID_IN,
    input wire nscr_evt_t EVT_IN,
    output logic EVT_READY_OUT,
    input wire logic TX_BUSY_IN,
    input wire logic RX_BUSY_IN,
    input wire logic BUS_MASTER_IN,
    input wire logic BUS_ERR_N_IN,
    input wire logic SELFTEST_FAIL_IN,
    input wire logic [3:0] SELFTEST_CODE_IN,
    output logic IRQ_OUT,
    output logic BOOT_N_OUT,
    output logic [1:0] TX_STATE_OUT,
    output logic [1:0] RX_STATE_OUT,
    output logic [1:0] OP_MODE_OUT,
    output logic [3:0] BURST_LIMIT_OUT,
    output logic SINGLE_CYCLE_OUT,
    output logic ABORT_OUT
);
    // The self-test counter in the state struct is twenty bits wide.
    if (SELFTEST_CYCLES < 1 || SELFTEST_CYCLES > (1 << 20)) begin : g_bad_st
        $error("Self-test cycle count does not fit the counter");
    end

    // Interrupt summary over the six event flags.
    function automatic logic summary(input nscr_state_t s);
        summary = s.tx_watchdog_flag | s.rx_watchdog_flag | s.memory_error_flag
            | s.rx_buffer_unavailable | s.rx_interrupt_flag | s.tx_interrupt_flag;
    endfunction

    // Status word as the host reads it.
    function automatic logic [31:0] status_word(input nscr_state_t s);
        logic [31:0] v;
        v = `NSCR_STATUS_ONES;
        v[`NSCR_SB_INIT] = s.init_done;
        v[`NSCR_SB_SF] = s.selftest_failed;
        v[`NSCR_SB_SS_HI:`NSCR_SB_SS_LO] = s.selftest_code;
        v[`NSCR_SB_TS_HI:`NSCR_SB_TS_LO] = s.tx_process_state;
        v[`NSCR_SB_RS_HI:`NSCR_SB_RS_LO] = s.rx_process_state;
        v[`NSCR_SB_OM_HI:`NSCR_SB_OM_LO] = s.operating_mode;
        v[`NSCR_SB_DN] = s.access_done;
        v[`NSCR_SB_BO] = s.boot_msg_seen;
        v[`NSCR_SB_TW] = s.tx_watchdog_flag;
        v[`NSCR_SB_RW] = s.rx_watchdog_flag;
        v[`NSCR_SB_ME] = s.memory_error_flag;
        v[`NSCR_SB_RU] = s.rx_buffer_unavailable;
        v[`NSCR_SB_RI] = s.rx_interrupt_flag;
        v[`NSCR_SB_TI] = s.tx_interrupt_flag;
        v[`NSCR_SB_IS] = summary(s);
        status_word = v;
    endfunction

    // Command word as the host reads it; the reset bit shows self-test.
    function automatic logic [31:0] command_word(input nscr_state_t s);
        logic [31:0] v;
        v = `NSCR_CMD_ONES;
        v[`NSCR_CB_RE] = !s.init_done;
        v[`NSCR_CB_IE] = s.interrupt_enable;
        v[`NSCR_CB_BL_HI:`NSCR_CB_BL_LO] = s.burst_limit;
        v[`NSCR_CB_BE] = s.boot_msg_enable;
        v[`NSCR_CB_SE] = s.single_cycle_enable;
        v[`NSCR_CB_ST] = s.tx_start_stop;
        v[`NSCR_CB_SR] = s.rx_start_stop;
        v[`NSCR_CB_OM_HI:`NSCR_CB_OM_LO] = s.operating_mode;
        v[7:0] = s.low_modes;
        command_word = v;
    endfunction

    nscr_state_t s_q; // Registered state.
    nscr_state_t s_d; // Next state.
    nscr_evt_t fifo_data; // Event at the FIFO head.
    logic fifo_valid; // FIFO holds an event.
    logic drain; // The sequencer takes the head event this cycle.
    logic [31:0] wd; // Host write data, for brevity.
    logic wr_ok; // Host write accepted at all.
    logic do_reset; // Reset command written this cycle.

    // Events queue here; the sequencer drains only when idle and after
    // self-test, so a busy engine really sees back-pressure.
    nscr_fifo #(
        .WIDTH($bits(nscr_evt_t)),
        .DEPTH(EVT_DEPTH)
    ) u_evt_fifo (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .in_valid_in(EVT_VALID_IN),
        .in_ready_out(EVT_READY_OUT),
        .in_data_in(EVT_IN),
        .out_valid_out(fifo_valid),
        .out_ready_in(drain),
        .out_data_out(fifo_data)
    );

    assign drain = (s_q.phase == NSCR_PH_IDLE) && s_q.init_done;

    // Next-state logic: host access, event sequencing, errors, reset.
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.abort = 1'b0;
        wd = HOST_REQ_IN.wdata;
        do_reset = 1'b0;
        // Commands are ignored until self-test is over.
        wr_ok = HOST_REQ_IN.wr && s_q.init_done && !HOST_REQ_IN.wperr;
        if (s_q.boot_cnt != 3'h0) begin
            s_d.boot_cnt = s_q.boot_cnt - 3'h1;
        end

        // Self-test runs after any reset, then leaves both processes stopped.
        if (!s_q.init_done) begin
            if (s_q.init_cnt == 20'(SELFTEST_CYCLES - 1)) begin
                s_d.init_done = 1'b1;
                s_d.selftest_failed = SELFTEST_FAIL_IN;
                s_d.selftest_code = SELFTEST_FAIL_IN ? SELFTEST_CODE_IN : 4'h0;
            end else begin
                s_d.init_cnt = s_q.init_cnt + 20'h1;
            end
        end

        // Host writes. State changes here raise no interrupt.
        if (wr_ok && HOST_REQ_IN.addr == `NSCR_ADDR_CMD) begin
            s_d.interrupt_enable = wd[`NSCR_CB_IE];
            s_d.boot_msg_enable = wd[`NSCR_CB_BE];
            do_reset = wd[`NSCR_CB_RE];
            if (s_q.tx_process_state == NSCR_PS_STOPPED
                && s_q.rx_process_state == NSCR_PS_STOPPED) begin
                s_d.burst_limit = wd[`NSCR_CB_BL_HI:`NSCR_CB_BL_LO];
                s_d.single_cycle_enable = wd[`NSCR_CB_SE];
                s_d.operating_mode = wd[`NSCR_CB_OM_HI:`NSCR_CB_OM_LO];
            end
            if (s_q.rx_process_state == NSCR_PS_STOPPED) begin
                s_d.low_modes = wd[7:0] & `NSCR_CMD_LOW_MASK;
            end
            // Start only from stopped with a list base once written.
            if (wd[`NSCR_CB_ST] && s_q.tx_process_state == NSCR_PS_STOPPED
                && s_q.tx_base_ok) begin
                s_d.tx_start_stop = 1'b1;
                s_d.tx_process_state = NSCR_PS_RUNNING;
            end else if (!wd[`NSCR_CB_ST]
                && s_q.tx_process_state != NSCR_PS_STOPPED) begin
                s_d.tx_start_stop = 1'b0;
                s_d.tx_stop_pend = 1'b1;
            end
            if (wd[`NSCR_CB_SR] && s_q.rx_process_state == NSCR_PS_STOPPED
                && s_q.rx_base_ok) begin
                s_d.rx_start_stop = 1'b1;
                s_d.rx_process_state = NSCR_PS_RUNNING;
            end else if (!wd[`NSCR_CB_SR]
                && s_q.rx_process_state != NSCR_PS_STOPPED) begin
                s_d.rx_start_stop = 1'b0;
                s_d.rx_stop_pend = 1'b1;
            end
        end
        // Write-one-to-clear; the event sets further down win over it.
        if (wr_ok && HOST_REQ_IN.addr == `NSCR_ADDR_STATUS) begin
            s_d.boot_msg_seen = s_q.boot_msg_seen & ~wd[`NSCR_SB_BO];
            s_d.tx_watchdog_flag = s_q.tx_watchdog_flag & ~wd[`NSCR_SB_TW];
            s_d.rx_watchdog_flag = s_q.rx_watchdog_flag & ~wd[`NSCR_SB_RW];
            s_d.memory_error_flag = s_q.memory_error_flag & ~wd[`NSCR_SB_ME];
            s_d.rx_buffer_unavailable = s_q.rx_buffer_unavailable & ~wd[`NSCR_SB_RU];
            s_d.rx_interrupt_flag = s_q.rx_interrupt_flag & ~wd[`NSCR_SB_RI];
            s_d.tx_interrupt_flag = s_q.tx_interrupt_flag & ~wd[`NSCR_SB_TI];
        end
        // List bases are only taken while the process is not running.
        if (wr_ok && HOST_REQ_IN.addr == `NSCR_ADDR_TXBASE
            && s_q.tx_process_state != NSCR_PS_RUNNING) begin
            s_d.tx_base_ok = 1'b1;
        end
        if (wr_ok && HOST_REQ_IN.addr == `NSCR_ADDR_RXBASE
            && s_q.rx_process_state != NSCR_PS_RUNNING) begin
            s_d.rx_base_ok = 1'b1;
        end

        // A stop waits for the frame in flight to finish.
        if (s_q.tx_stop_pend && !TX_BUSY_IN) begin
            s_d.tx_stop_pend = 1'b0;
            s_d.tx_process_state = NSCR_PS_STOPPED;
        end
        if (s_q.rx_stop_pend && !RX_BUSY_IN) begin
            s_d.rx_stop_pend = 1'b0;
            s_d.rx_process_state = NSCR_PS_STOPPED;
        end

        // Event sequencer: states in the high half first, flags one cycle
        // later in the low half, so a poller never sees flags before state.
        case (s_q.phase)
            NSCR_PH_IDLE: begin
                if (drain && fifo_valid) begin
                    s_d.ev = fifo_data;
                    s_d.phase = NSCR_PH_HIGH;
                end
            end
            NSCR_PH_HIGH: begin
                if (s_q.ev.tx_wdog && s_q.tx_process_state != NSCR_PS_STOPPED) begin
                    s_d.tx_process_state = NSCR_PS_STOPPED;
                end else if ((s_q.ev.tx_empty || s_q.ev.tx_err)
                    && s_q.tx_process_state == NSCR_PS_RUNNING) begin
                    s_d.tx_process_state = NSCR_PS_SUSPENDED;
                end else if (s_q.ev.tx_resume
                    && s_q.tx_process_state == NSCR_PS_SUSPENDED) begin
                    s_d.tx_process_state = NSCR_PS_RUNNING;
                end
                // A watchdog cut keeps reception running.
                if (s_q.ev.rx_unavail && s_q.rx_process_state == NSCR_PS_RUNNING) begin
                    s_d.rx_process_state = NSCR_PS_SUSPENDED;
                end else if (s_q.ev.rx_resume
                    && s_q.rx_process_state == NSCR_PS_SUSPENDED) begin
                    s_d.rx_process_state = NSCR_PS_RUNNING;
                end
                if (s_q.ev.access_start) begin
                    s_d.access_done = 1'b0;
                end
                if (s_q.ev.access_done) begin
                    s_d.access_done = 1'b1;
                end
                s_d.phase = NSCR_PH_LOW;
            end
            NSCR_PH_LOW: begin
                if (s_q.ev.tx_wdog) begin
                    s_d.tx_watchdog_flag = 1'b1;
                end
                if (s_q.ev.rx_wdog) begin
                    s_d.rx_watchdog_flag = 1'b1;
                end
                if (s_q.ev.rx_frame || s_q.ev.rx_wdog) begin
                    s_d.rx_interrupt_flag = 1'b1;
                end
                if (s_q.ev.tx_empty || s_q.ev.tx_err || s_q.ev.tx_ic) begin
                    s_d.tx_interrupt_flag = 1'b1;
                end
                // Any unavailable event that finds reception suspended flags, unless it also carries resume.
                if (s_q.ev.rx_unavail && s_q.rx_process_state == NSCR_PS_SUSPENDED
                    && s_q.ev.rx_resume == 1'b0) begin
                    s_d.rx_buffer_unavailable = 1'b1;
                end
                if (s_q.ev.boot_msg && s_q.boot_msg_enable) begin
                    s_d.boot_msg_seen = 1'b1;
                    s_d.boot_cnt = `NSCR_BOOT_PULSE_CYCLES;
                end
                s_d.phase = NSCR_PH_IDLE;
            end
            default: begin
                s_d.phase = NSCR_PH_IDLE;
            end
        endcase

        // Memory errors: bus error while master, or parity on a host write.
        if ((BUS_MASTER_IN && !BUS_ERR_N_IN)
            || (HOST_REQ_IN.wr && HOST_REQ_IN.wperr)) begin
            s_d.memory_error_flag = 1'b1;
            s_d.tx_process_state = NSCR_PS_STOPPED;
            s_d.rx_process_state = NSCR_PS_STOPPED;
            s_d.tx_start_stop = 1'b0;
            s_d.rx_start_stop = 1'b0;
            s_d.tx_stop_pend = 1'b0;
            s_d.rx_stop_pend = 1'b0;
            s_d.abort = 1'b1;
        end

        // Reset command: abort everything and rerun self-test. Flags and
        // the command word come back to their reset values.
        if (do_reset) begin
            s_d = '0;
            s_d.access_done = 1'b1;
            s_d.burst_limit = `NSCR_BL_DEFAULT;
            s_d.abort = 1'b1;
        end

        // Host reads answer one cycle later; unmapped addresses read zero.
        if (HOST_REQ_IN.rd) begin
            s_d.rvalid = 1'b1;
            if (HOST_REQ_IN.addr == `NSCR_ADDR_STATUS) begin
                s_d.rdata = status_word(s_q);
            end else if (HOST_REQ_IN.addr == `NSCR_ADDR_CMD) begin
                s_d.rdata = command_word(s_q);
            end else begin
                s_d.rdata = 32'h0;
            end
        end

        // Registered outputs derived from the next state.
        s_d.irq = s_d.interrupt_enable && summary(s_d);
        s_d.boot_n = (s_d.boot_cnt == 3'h0);
        // Single-cycle mode folds bursts of 2 and 8 down to 1 and 4.
        if (s_d.single_cycle_enable && s_d.burst_limit == 4'h2) begin
            s_d.burst_eff = 4'h1;
        end else if (s_d.single_cycle_enable && s_d.burst_limit == 4'h8) begin
            s_d.burst_eff = 4'h4;
        end else begin
            s_d.burst_eff = s_d.burst_limit;
        end
    end

    // State register; after hardware reset self-test starts at once.
    always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            s_q <= '0;
            s_q.access_done <= 1'b1;
            s_q.burst_limit <= `NSCR_BL_DEFAULT;
            s_q.burst_eff <= `NSCR_BL_DEFAULT;
            s_q.boot_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign HOST_RDATA_OUT = s_q.rdata;
    assign HOST_RVALID_OUT = s_q.rvalid;
    assign IRQ_OUT = s_q.irq;
    assign BOOT_N_OUT = s_q.boot_n;
    assign TX_STATE_OUT = s_q.tx_process_state;
    assign RX_STATE_OUT = s_q.rx_process_state;
    assign OP_MODE_OUT = s_q.operating_mode;
    assign BURST_LIMIT_OUT = s_q.burst_eff;
    assign SINGLE_CYCLE_OUT = s_q.single_cycle_enable;
    assign ABORT_OUT = s_q.abort;
endmodule
`default_nettype wire

// ### bench/nscr_checker.sv
// Port checks for the status and command register block.
// Assumes it is bound into nscr_regs and runs on the host clock.
`timescale 1ns/10ps
`default_nettype none
module nscr_checker import nscr_pkg::*; (
    input wire logic SYS_CLK_IN,
    input wire logic RSTN_IN,
    input wire nscr_req_t HOST_REQ_IN,
    input wire logic BUS_MASTER_IN,
    input wire logic BUS_ERR_N_IN,
    input wire logic IRQ_OUT,
    input wire logic BOOT_N_OUT,
    input wire logic [1:0] TX_STATE_OUT,
    input wire logic [1:0] RX_STATE_OUT,
    input wire logic [3:0] BURST_LIMIT_OUT,
    input wire logic SINGLE_CYCLE_OUT
);
    // One domain, so one clock and one disable serve every check.
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    state_code_a: assert property (TX_STATE_OUT != 2'h3 && RX_STATE_OUT != 2'h3)
        else $error("reserved process state");
    err_stop_a: assert property (BUS_MASTER_IN && !BUS_ERR_N_IN
        |=> TX_STATE_OUT == 2'h0 && RX_STATE_OUT == 2'h0) else $error("error kept a process");
    boot_pulse_a: assert property ($fell(BOOT_N_OUT) |-> !BOOT_N_OUT [*6] ##1 BOOT_N_OUT)
        else $error("boot pulse length");
    // The write guard spans two cycles, though the request output is registered in the same cycle as its flags.
    irq_hold_a: assert property (IRQ_OUT && !HOST_REQ_IN.wr && !$past(HOST_REQ_IN.wr)
        |=> IRQ_OUT) else $error("interrupt dropped unasked");
    burst_set_a: assert property (BURST_LIMIT_OUT inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("burst limit illegal");
    burst_fold_a: assert property (SINGLE_CYCLE_OUT |-> BURST_LIMIT_OUT inside {4'h1, 4'h4})
        else $error("burst not folded");
    tx_hold_a: assert property (TX_STATE_OUT == 2'h0 && !HOST_REQ_IN.wr
        |=> TX_STATE_OUT == 2'h0) else $error("tx left stop unasked");
    rx_hold_a: assert property (RX_STATE_OUT == 2'h0 && !HOST_REQ_IN.wr
        |=> RX_STATE_OUT == 2'h0) else $error("rx left stop unasked");
endmodule
bind nscr_regs nscr_checker nscr_checker_i (.SYS_CLK_IN(SYS_CLK_IN), .RSTN_IN(RSTN_IN),
    .HOST_REQ_IN(HOST_REQ_IN), .BUS_MASTER_IN(BUS_MASTER_IN), .BUS_ERR_N_IN(BUS_ERR_N_IN),
    .IRQ_OUT(IRQ_OUT), .BOOT_N_OUT(BOOT_N_OUT), .TX_STATE_OUT(TX_STATE_OUT),
    .RX_STATE_OUT(RX_STATE_OUT), .BURST_LIMIT_OUT(BURST_LIMIT_OUT),
    .SINGLE_CYCLE_OUT(SINGLE_CYCLE_OUT));
`default_nettype wire

// ### bench/nscr_engine.sv
// Frame engine stand-in that hands event words to the register block.
// Assumes the bench calls send and the block answers with ready.
`timescale 1ns/10ps
`default_nettype none
module nscr_engine import nscr_pkg::*; (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic valid_out,
    output var nscr_evt_t evt_out
);
    initial begin
        valid_out = 1'b0;
        evt_out = '0;
    end
    // Holds the word until ready is seen at a rising edge, then shows its inverse.
    task automatic send(input nscr_evt_t e);
        @(negedge clk_in);
        valid_out = 1'b1;
        evt_out = e;
        @(posedge clk_in);
        while (!ready_in) @(posedge clk_in);
        @(negedge clk_in);
        valid_out = 1'b0;
        evt_out = ~e;
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the status and command register block.
// Assumes a 16-cycle self-test and the engine stand-in on the event port.
`timescale 1ns/10ps
`default_nettype none
`include "nscr_defines.svh"
module testbench import nscr_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, mst = 1'b0, err_n = 1'b1, rdy, vld, rv, irq, bn, sc, ab;
    logic [1:0] ts, rs, om;
    logic [3:0] bl;
    logic [31:0] rd;
    nscr_req_t req = '0;
    nscr_evt_t evt;
    int fail_count = 0, checks_done = 0, cyc = 0;
    nscr_regs #(.SELFTEST_CYCLES(16)) nscr_regs_i (.SYS_CLK_IN(clk), .RSTN_IN(rstn),
        .HOST_REQ_IN(req), .HOST_RDATA_OUT(rd), .HOST_RVALID_OUT(rv), .EVT_VALID_IN(vld),
        .EVT_IN(evt), .EVT_READY_OUT(rdy), .TX_BUSY_IN(1'b0), .RX_BUSY_IN(1'b0),
        .BUS_MASTER_IN(mst), .BUS_ERR_N_IN(err_n), .SELFTEST_FAIL_IN(1'b0),
        .SELFTEST_CODE_IN(4'h0), .IRQ_OUT(irq), .BOOT_N_OUT(bn), .TX_STATE_OUT(ts),
        .RX_STATE_OUT(rs), .OP_MODE_OUT(om), .BURST_LIMIT_OUT(bl), .SINGLE_CYCLE_OUT(sc),
        .ABORT_OUT(ab));
    nscr_engine nscr_engine_i (.clk_in(clk), .ready_in(rdy), .valid_out(vld), .evt_out(evt));
    initial forever #12.5 clk = ~clk;
    // A hang costs a mismatch; the whole run needs well under this many cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle register access; a read is judged against d in the answer cycle.
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{rd: !w, wr: w, addr: a, wdata: d, wperr: 1'b0};
        @(negedge clk);
        req = '0;
        if (!w) begin
            chk("rvalid", 32'(rv), 32'h1);
            chk("rdata", rd, d);
        end
    endtask
    task automatic t_reset();
        acc(0, `NSCR_ADDR_STATUS, 32'h0039ff00);
        repeat (20) @(negedge clk);
        acc(0, `NSCR_ADDR_CMD, 32'h03e0f000);
    endtask
    task automatic t_tx_event();
        acc(1, `NSCR_ADDR_TXBASE, 32'h100);
        acc(1, `NSCR_ADDR_CMD, 32'h44080900);
        chk("tx state", 32'(ts), 32'h1);
        chk("mode", 32'(om), 32'h1);
        chk("burst", {27'h0, sc, bl}, 32'h11);
        nscr_engine_i.send(nscr_evt_t'(12'h200));
        for (int i = 0; i < 8 && irq !== 1'b1; i++) @(negedge clk);
        chk("irq", 32'(irq), 32'h1);
        chk("tx state", 32'(ts), 32'h2);
        acc(0, `NSCR_ADDR_STATUS, 32'h823bff03);
        acc(1, `NSCR_ADDR_STATUS, 32'h2);
        acc(0, `NSCR_ADDR_STATUS, 32'h823bff00);
        chk("irq", 32'(irq), 32'h0);
    endtask
    task automatic t_boot();
        int n = 0;
        acc(1, `NSCR_ADDR_CMD, 32'h40100000);
        nscr_engine_i.send(nscr_evt_t'(12'h004));
        for (int i = 0; i < 8 && bn !== 1'b0; i++) @(negedge clk);
        for (; n < 9 && bn === 1'b0; n++) @(negedge clk);
        chk("boot pulse", n, 32'd6);
        acc(0, `NSCR_ADDR_STATUS, 32'h803bff80);
    endtask
    task automatic t_error();
        acc(1, `NSCR_ADDR_RXBASE, 32'h200);
        acc(1, `NSCR_ADDR_CMD, 32'h42100c00);
        nscr_engine_i.send(nscr_evt_t'(12'h060));
        repeat (4) @(negedge clk);
        chk("rx state", 32'(rs), 32'h2);
        mst = 1'b1;
        err_n = 1'b0;
        @(negedge clk);
        chk("abort", {27'h0, ab, rs, ts}, 32'h10);
        mst = 1'b0;
        err_n = 1'b1;
        acc(0, `NSCR_ADDR_STATUS, 32'h8039ff9d);
        acc(1, `NSCR_ADDR_CMD, 32'h80000000);
        acc(0, `NSCR_ADDR_STATUS, 32'h0039ff00);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_tx_event();
        t_boot();
        t_error();
        give_verdict();
    end
endmodule
`default_nettype wire
